// ==== thermal_zone_alarm_control.sv ====
// Two-wire register slave, alarm logic and conversion control of the supervisor
`timescale 1ns/1ps
// Overview of operation
// - Site write ends, fresh conversion starts
// - Own address seen halts and resets conversion
// - Conversion resumes only after transaction ends
// - Alarm updates on next completed conversion
// - Status reflects new site after depth conversions
// - One control register for active site
// - Eight control bits, top bit read-only status
// - Status bit sets even while alarm masked
// - Control read clears pending alarm and status
// - Low thresholds with 02h read back 82h
// - Thresholds are 9-bit two's complement half-degrees
// - Raised thresholds give under-temperature alarm next
// - Site bit one remote, zero internal
// - Entering interrupt behaviour watches over-temperature first
// - Interrupt behaviour alternates over and under watch
// - Control register resets to all zeros
// - Status set below hysteresis or above setpoint
// - Behaviour bit one interrupt, zero comparator
// - Result sits in bits fifteen to seven
module thermal_zone_alarm_control #(
  parameter int CONV_CYCLES_P = thermal_pkg::CONV_CYCLES
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [2:0] addr_pins,
  input wire logic [8:0] temp_in,
  output logic zone_sel,
  output logic int_o,
  output logic int_oe
);
  import thermal_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; edge detection reads only the second stage onward

  logic scl_s1_q, scl_s2_q, scl_p_q;
  logic sda_s1_q, sda_s2_q, sda_p_q;
  logic [2:0] adr_s1_q, adr_s2_q;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_p_q <= 1'b1;
      adr_s1_q <= 3'h0;
      adr_s2_q <= 3'h0;
    end else begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_p_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_p_q <= sda_s2_q;
      adr_s1_q <= addr_pins;
      adr_s2_q <= adr_s1_q;
    end
  end

  logic scl_rise, scl_fall, start_ev, stop_ev;
  assign scl_rise = scl_s2_q & ~scl_p_q;
  assign scl_fall = ~scl_s2_q & scl_p_q;
  assign start_ev = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
  assign stop_ev = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register state and the conversion sequencer

  cfg_type cfg_q, cfg_d;
  logic [8:0] hyst_q, hyst_d, set_q, set_d, temp_q, temp_d;
  logic watch_over_q, watch_over_d, pend_q, pend_d, comp_q, comp_d;
  logic [2:0] cnt_q, cnt_d;
  logic int_oe_q, int_oe_d;
  logic busy_q, busy_d;
  logic conv_done;
  logic [8:0] conv_result;

  // Halted whole while addressed, so the next conversion after any write
  // measures whatever site was just selected
  conv_timer #(
    .CYCLES(CONV_CYCLES_P)
  ) u_conv (
    .mclk(mclk),
    .nrst(nrst),
    .halt(busy_q | cfg_q.shdn),
    .temp_in(temp_in),
    .done(conv_done),
    .result(conv_result)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Two-wire slave

  bus_state_type st_q, st_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d, hi_q, hi_d;
  logic [1:0] ptr_q, ptr_d;
  logic first_q, first_d, idx_q, idx_d, rw_q, rw_d, nack_q, nack_d;
  logic sda_oe_q, sda_oe_d;
  logic wr_cfg, wr_hyst, wr_set, rd_cfg;
  logic [7:0] wdata;
  logic [7:0] tx_sel;
  logic nidx;

  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    tx_d = tx_q;
    hi_d = hi_q;
    ptr_d = ptr_q;
    first_d = first_q;
    idx_d = idx_q;
    rw_d = rw_q;
    nack_d = nack_q;
    sda_oe_d = sda_oe_q;
    busy_d = busy_q;
    wr_cfg = 1'b0;
    wr_hyst = 1'b0;
    wr_set = 1'b0;
    rd_cfg = 1'b0;
    wdata = sh_q;
    nidx = (st_q == BS_AACK) ? 1'b0 : ~idx_q;
    tx_sel = 8'h00;
    case (ptr_q)
      PTR_TEMP: tx_sel = nidx ? {temp_q[0], 7'h00} : temp_q[8:1];
      PTR_CFG: tx_sel = cfg_q;
      PTR_HYST: tx_sel = nidx ? {hyst_q[0], 7'h00} : hyst_q[8:1];
      default: tx_sel = nidx ? {set_q[0], 7'h00} : set_q[8:1];
    endcase
    if (stop_ev) begin
      st_d = BS_IDLE;
      sda_oe_d = 1'b0;
      busy_d = 1'b0;
    end else if (start_ev) begin
      st_d = BS_ADDR;
      bit_d = 4'h0;
      sda_oe_d = 1'b0;
    end else begin
      case (st_q)
        BS_ADDR: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_s2_q};
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == BITS_PER_BYTE) begin
            if (sh_q[7:1] == {ADDR_BASE, adr_s2_q}) begin
              busy_d = 1'b1;
              rw_d = sh_q[0];
              sda_oe_d = 1'b1;
              st_d = BS_AACK;
            end else begin
              busy_d = 1'b0;
              st_d = BS_IDLE;
            end
          end
        end
        BS_AACK: begin
          if (scl_fall) begin
            bit_d = 4'h0;
            first_d = 1'b1;
            if (rw_q) begin
              idx_d = 1'b0;
              tx_d = tx_sel;
              rd_cfg = (ptr_q == PTR_CFG);
              sda_oe_d = ~tx_sel[7];
              st_d = BS_TX;
            end else begin
              sda_oe_d = 1'b0;
              st_d = BS_RX;
            end
          end
        end
        BS_RX: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_s2_q};
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == BITS_PER_BYTE) begin
            sda_oe_d = 1'b1;
            st_d = BS_RACK;
            if (first_q) begin
              ptr_d = sh_q[1:0];
              first_d = 1'b0;
              idx_d = 1'b0;
            end else begin
              idx_d = ~idx_q;
              if (ptr_q == PTR_CFG) begin
                wr_cfg = 1'b1;
              end else if (!idx_q) begin
                hi_d = sh_q;
              end else if (ptr_q == PTR_HYST) begin
                wr_hyst = 1'b1;
              end else if (ptr_q == PTR_SET) begin
                wr_set = 1'b1;
              end
            end
          end
        end
        BS_RACK: begin
          if (scl_fall) begin
            sda_oe_d = 1'b0;
            bit_d = 4'h0;
            st_d = BS_RX;
          end
        end
        BS_TX: begin
          if (scl_rise) begin
            bit_d = bit_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_q == BITS_PER_BYTE) begin
              sda_oe_d = 1'b0;
              st_d = BS_MACK;
            end else begin
              tx_d = {tx_q[6:0], 1'b0};
              sda_oe_d = ~tx_q[6];
            end
          end
        end
        BS_MACK: begin
          if (scl_rise) begin
            nack_d = sda_s2_q;
          end else if (scl_fall) begin
            if (nack_q) begin
              st_d = BS_IDLE;
            end else begin
              idx_d = nidx;
              tx_d = tx_sel;
              rd_cfg = (ptr_q == PTR_CFG);
              sda_oe_d = ~tx_sel[7];
              bit_d = 4'h0;
              st_d = BS_TX;
            end
          end
        end
        default: st_d = BS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm logic

  logic trig, active;
  logic [2:0] cnt_inc;

  always_comb begin
    cfg_d = cfg_q;
    hyst_d = hyst_q;
    set_d = set_q;
    temp_d = temp_q;
    watch_over_d = watch_over_q;
    pend_d = pend_q;
    comp_d = comp_q;
    cnt_d = cnt_q;
    trig = 1'b0;
    cnt_inc = cnt_q + 3'h1;
    if (wr_cfg) begin
      cfg_d = {cfg_q.alert_status_bit, wdata[6:0]};
      cnt_d = 3'h0;
      if (!cfg_q.mode && wdata[1]) begin
        watch_over_d = 1'b1;
      end
    end
    if (wr_hyst) begin
      hyst_d = {hi_q, sh_q[7]};
    end
    if (wr_set) begin
      set_d = {hi_q, sh_q[7]};
    end
    if (rd_cfg) begin
      cfg_d.alert_status_bit = 1'b0;
      pend_d = 1'b0;
    end
    // Conversion results are handled last so a set beats a same-cycle clear
    if (conv_done) begin
      temp_d = conv_result;
      if (watch_over_q) begin
        trig = $signed(conv_result) > $signed(set_q);
      end else begin
        trig = $signed(conv_result) < $signed(hyst_q);
      end
      if (!trig) begin
        cnt_d = 3'h0;
      end else if (cnt_inc >= fault_depth(cfg_q.fq)) begin
        cnt_d = 3'h0;
        cfg_d.alert_status_bit = 1'b1;
        pend_d = cfg_d.mode;
        comp_d = watch_over_q;
        watch_over_d = ~watch_over_q;
      end else begin
        cnt_d = cnt_inc;
      end
    end
    active = cfg_d.mode ? pend_d : comp_d;
    // Mask releases the pin; polarity picks which state pulls it low
    int_oe_d = ~cfg_d.interrupt_mask_bit & (active ^ cfg_d.pol);
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st_q <= BS_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      hi_q <= 8'h00;
      ptr_q <= PTR_TEMP;
      first_q <= 1'b0;
      idx_q <= 1'b0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oe_q <= 1'b0;
      busy_q <= 1'b0;
      cfg_q <= CFG_RESET;
      hyst_q <= HYST_RESET;
      set_q <= SET_RESET;
      temp_q <= TEMP_RESET;
      watch_over_q <= 1'b1;
      pend_q <= 1'b0;
      comp_q <= 1'b0;
      cnt_q <= 3'h0;
      int_oe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      hi_q <= hi_d;
      ptr_q <= ptr_d;
      first_q <= first_d;
      idx_q <= idx_d;
      rw_q <= rw_d;
      nack_q <= nack_d;
      sda_oe_q <= sda_oe_d;
      busy_q <= busy_d;
      cfg_q <= cfg_d;
      hyst_q <= hyst_d;
      set_q <= set_d;
      temp_q <= temp_d;
      watch_over_q <= watch_over_d;
      pend_q <= pend_d;
      comp_q <= comp_d;
      cnt_q <= cnt_d;
      int_oe_q <= int_oe_d;
    end
  end

  // Open-drain pins only ever pull low
  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_q;
  assign int_o = 1'b0;
  assign int_oe = int_oe_q;
  assign zone_sel = cfg_q.zone;
endmodule // thermal_zone_alarm_control

// ==== thermal_pkg.sv ====
// Shared constants, types and helpers for the thermal zone supervisor
package thermal_pkg;

  localparam int CLK_HZ = 25_000_000;
  localparam int CONV_TIME_MS = 160;
  // Longest conversion time, rounded down to whole clock cycles
  localparam int CONV_CYCLES = CONV_TIME_MS * (CLK_HZ / 1000);

  // Command byte (pointer) codes
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CFG = 2'h1;
  localparam logic [1:0] PTR_HYST = 2'h2;
  localparam logic [1:0] PTR_SET = 2'h3;

  // Upper four bits of the target address; low three come from the address pins
  localparam logic [3:0] ADDR_BASE = 4'h9;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [8:0] HYST_RESET = 9'h096;
  localparam logic [8:0] SET_RESET = 9'h0a0;
  localparam logic [8:0] TEMP_RESET = 9'h000;

  typedef struct packed {
    logic alert_status_bit;
    logic interrupt_mask_bit;
    logic zone;
    logic [1:0] fq;
    logic pol;
    logic mode;
    logic shdn;
  } cfg_type;

  typedef enum logic [2:0] {
    BS_IDLE = 3'b000,
    BS_ADDR = 3'b001,
    BS_AACK = 3'b010,
    BS_RX = 3'b011,
    BS_RACK = 3'b100,
    BS_TX = 3'b101,
    BS_MACK = 3'b110
  } bus_state_type;

  // Fault queue depth code to number of consecutive conversions
  function automatic logic [2:0] fault_depth(input logic [1:0] code);
    logic [2:0] d;
    d = 3'h1;
    case (code)
      2'h0: d = 3'h1;
      2'h1: d = 3'h2;
      2'h2: d = 3'h4;
      default: d = 3'h6;
    endcase
    return d;
  endfunction

endpackage

// ==== conv_timer.sv ====
// Conversion sequencer: back-to-back conversions, reset while halted
`timescale 1ns/1ps
module conv_timer #(
  parameter int CYCLES = 4000000
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic halt,
  input wire logic [8:0] temp_in,
  output logic done,
  output logic [8:0] result
);
  import thermal_pkg::*;

  logic [31:0] cnt_q, cnt_d;
  logic done_q, done_d;
  logic [8:0] res_q, res_d;

  always_comb begin
    done_d = 1'b0;
    res_d = res_q;
    if (halt) begin
      cnt_d = 32'h0;
    end else if (cnt_q == 32'(CYCLES - 1)) begin
      cnt_d = 32'h0;
      done_d = 1'b1;
      res_d = temp_in;
    end else begin
      cnt_d = cnt_q + 32'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cnt_q <= 32'h0;
      done_q <= 1'b0;
      res_q <= TEMP_RESET;
    end else begin
      cnt_q <= cnt_d;
      done_q <= done_d;
      res_q <= res_d;
    end
  end

  assign done = done_q;
  assign result = res_q;
endmodule // conv_timer

// ==== thermal_sva.sv ====
// Pin-level checks for the thermal zone supervisor
`timescale 1ns/1ps
module thermal_sva #(
  parameter int CONV_CYCLES_P = 100
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic [2:0] addr_pins,
  input wire logic [8:0] temp_in,
  input wire logic zone_sel,
  input wire logic int_o,
  input wire logic int_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  chk_sda_drive_zero: assert property (sda_o == 1'b0)
    else $error("data pin drive value not low");
  chk_alarm_drive_zero: assert property (int_o == 1'b0)
    else $error("alarm pin drive value not low");
  chk_reset_quiet: assert property (disable iff (1'b0) !nrst |=> !sda_oe && !int_oe && !zone_sel)
    else $error("outputs active after reset");
  chk_data_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data drive changed while clock high");
  chk_data_held: assert property ($rose(sda_oe) |-> sda_oe [*4])
    else $error("data drive too short");
  chk_idle_release: assert property (scl_in [*8] |-> !sda_oe)
    else $error("data driven on idle bus");
  chk_zone_at_ack: assert property ($changed(zone_sel) |-> sda_oe || $past(sda_oe) || $past(sda_oe, 2))
    else $error("site changed outside a control write");
  // Conversion restarts from zero at the stop ending a transfer to this device, so the alarm cannot move right after it
  chk_quiet_after_stop: assert property (scl_in && $rose(sda_in) |=> $stable(int_oe) [*8])
    else $error("alarm moved just after a stop");
  cover property ($rose(int_oe));
  cover property ($rose(zone_sel));
  cover property (scl_in && $fell(sda_in));
endmodule // thermal_sva

// ==== host_model.sv ====
// Two-wire bus host model with open-drain data line
`timescale 1ns/1ps
module host_model (
  input wire logic sda_oe,
  input wire logic [6:0] dev_addr,
  output logic scl,
  output logic sda
);
  logic pull_low = 1'b0;
  initial scl = 1'b1;
  // Pulled-up wire: a released line reads high
  assign sda = !(pull_low || sda_oe);
  task automatic bit_x(input logic b, output logic r);
    pull_low = !b;
    #80 scl = 1'b1;
    #80 r = sda;
    #80 scl = 1'b0;
    #80;
  endtask
  task automatic byte_x(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(m, s);
    a = !s;
  endtask
  // Also serves as repeated start; the clock is idle high between frames
  task automatic start();
    pull_low = 1'b0;
    // The device lets go of its acknowledge a few clocks after the fall;
    // raising the clock sooner would make that release look like a stop
    #160 scl = 1'b1;
    #80 pull_low = 1'b1;
    #80 scl = 1'b0;
    #80;
  endtask
  task automatic xfer(input logic rd, input logic [7:0] ptr, input int n, input logic [15:0] wv,
                      output logic [15:0] rv, output logic ack);
    logic [7:0] q;
    logic a;
    rv = 16'h0;
    start();
    byte_x({dev_addr, 1'b0}, 1'b1, q, ack);
    byte_x(ptr, 1'b1, q, a);
    if (rd) begin
      start();
      byte_x({dev_addr, 1'b1}, 1'b1, q, a);
    end
    for (int i = 0; i < n; i++) begin
      byte_x(rd ? 8'hff : wv[15-8*i -: 8], rd ? (i == n - 1) : 1'b1, q, a);
      rv[15-8*i -: 8] = q;
    end
    pull_low = 1'b1;
    #160 scl = 1'b1;
    #80 pull_low = 1'b0;
    #160;
  endtask
endmodule // host_model

// ==== tb_top.sv ====
// Self-checking bench for the thermal zone supervisor
`timescale 1ns/1ps
module tb_top;
  import thermal_pkg::*;
  localparam int CONV = 100;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] addr_pins = 3'h0;
  logic [8:0] temp_in = 9'h000;
  logic [6:0] dev_addr = 7'h48;
  logic scl, sda, sda_o, sda_oe, zone_sel, int_o, int_oe, ack;
  logic [15:0] rv;
  logic [7:0] cfg;
  logic [31:0] seed = 32'hb644;
  int num_errors = 0;
  int n_compared = 0;
  always #20 mclk = !mclk;
  thermal_zone_alarm_control #(.CONV_CYCLES_P(CONV)) thermal_zone_alarm_control_i (.mclk(mclk),
    .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_pins(addr_pins), .temp_in(temp_in), .zone_sel(zone_sel), .int_o(int_o), .int_oe(int_oe));
  host_model host_model_i (.sda_oe(sda_oe), .dev_addr(dev_addr), .scl(scl), .sda(sda));
  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic int depth(input logic [1:0] c);
    return (c == 2'h3) ? 6 : (1 << c);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic r, input logic [1:0] p, input int n, input logic [15:0] v);
    host_model_i.xfer(r, {6'h0, p}, n, v, rv, ack);
  endtask
  task automatic thr(input logic [15:0] v);
    bus(1'b0, PTR_SET, 2, v);
    bus(1'b0, PTR_HYST, 2, v);
  endtask
  // Bounded wait: a lost alarm shows up as a mismatch, not a hang
  task automatic wait_int();
    int k;
    k = 0;
    while (int_oe !== 1'b1 && k < 3 * CONV) begin
      @(negedge mclk);
      k++;
    end
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    cyc(60000);
    num_errors++;
    $display("watchdog expired");
    final_report();
  end
  initial begin
    seed = xs(seed);
    addr_pins = seed[2:0];
    dev_addr = {ADDR_BASE, seed[2:0]};
    cyc(20);
    nrst = 1'b1;
    cyc(3);
    check({14'h0, zone_sel, int_oe}, 16'h0);
    bus(1'b1, PTR_CFG, 1, 16'h0);
    check(rv, 16'h0000);
    bus(1'b1, PTR_HYST, 2, 16'h0);
    check(rv & 16'hff80, 16'h4b00);
    bus(1'b1, PTR_SET, 2, 16'h0);
    check(rv & 16'hff80, 16'h5000);
    dev_addr[0] = !dev_addr[0];
    bus(1'b0, PTR_CFG, 1, 16'h4400);
    check({15'h0, ack}, 16'h0);
    dev_addr[0] = !dev_addr[0];
    bus(1'b1, PTR_CFG, 1, 16'h0);
    check(rv, 16'h0000);
    $display("test reset done");
    seed = xs(seed);
    temp_in = 9'(int'(seed % 32'd365) - 110);
    bus(1'b0, PTR_CFG, 1, 16'h0200);
    thr(16'hc880);
    wait_int();
    check({15'h0, int_oe}, 16'h1);
    bus(1'b1, PTR_TEMP, 2, 16'h0);
    check(rv & 16'hff80, {temp_in, 7'h0});
    bus(1'b1, PTR_CFG, 1, 16'h0);
    check(rv, 16'h8200);
    cyc(2);
    check({15'h0, int_oe}, 16'h0);
    thr(16'h7f80);
    wait_int();
    check({15'h0, int_oe}, 16'h1);
    bus(1'b1, PTR_CFG, 1, 16'h0);
    check(rv, 16'h8200);
    cyc(3 * CONV);
    check({15'h0, int_oe}, 16'h0);
    bus(1'b1, PTR_CFG, 1, 16'h0);
    check(rv, 16'h0200);
    $display("test identify done");
    seed = xs(seed);
    cfg = {3'b001, seed[1:0], 3'b000};
    bus(1'b0, PTR_CFG, 1, {cfg, 8'h0});
    check({15'h0, zone_sel}, 16'h1);
    thr(16'hc880);
    cyc((depth(seed[1:0]) - 1) * CONV + CONV / 2);
    check({15'h0, int_oe}, 16'h0);
    cyc(CONV);
    check({15'h0, int_oe}, 16'h1);
    bus(1'b1, PTR_CFG, 1, 16'h0);
    check(rv, {1'b1, cfg[6:0], 8'h0});
    $display("test zone done");
    bus(1'b0, PTR_CFG, 1, 16'h4400);
    thr(16'h7f80);
    cyc(CONV + CONV / 2);
    check({15'h0, int_oe}, 16'h0);
    bus(1'b1, PTR_CFG, 1, 16'h0);
    check(rv, 16'hc400);
    bus(1'b0, PTR_CFG, 1, 16'h0400);
    cyc(4);
    check({15'h0, int_oe}, 16'h1);
    $display("test mask done");
    bus(1'b0, PTR_CFG, 1, 16'h4400);
    bus(1'b1, PTR_CFG, 1, 16'h0);
    check(rv, 16'h4400);
    seed = xs(seed);
    temp_in = 9'(int'(seed % 32'd365) - 110);
    thr(16'hc880);
    bus(1'b0, PTR_CFG, 1, 16'h2000);
    check({15'h0, zone_sel}, 16'h1);
    bus(1'b0, PTR_CFG, 1, 16'h2200);
    cyc(CONV / 2);
    check({15'h0, int_oe}, 16'h0);
    cyc(CONV);
    check({15'h0, int_oe}, 16'h1);
    bus(1'b1, PTR_TEMP, 2, 16'h0);
    check(rv & 16'hff80, {temp_in, 7'h0});
    $display("test site done");
    final_report();
  end
endmodule // tb_top
bind thermal_zone_alarm_control thermal_sva #(.CONV_CYCLES_P(CONV_CYCLES_P)) thermal_sva_i (
  .mclk(mclk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_o(sda_o), .sda_oe(sda_oe),
  .addr_pins(addr_pins), .temp_in(temp_in), .zone_sel(zone_sel), .int_o(int_o), .int_oe(int_oe));
